// ===== pkg/ext_bus_pkg.sv
package ext_bus_pkg;
   localparam int ADDR_W = 28;
   localparam int DATA_W = 32;
   localparam int LANES = 4;
   localparam int REGIONS = 5;
   localparam int BOOT_REGION = 0;
   localparam int RELEASE_CYCLES = 1;
   localparam logic [3:0] COL_IDLE = 4'hf;
   localparam logic [3:0] LANES_IDLE = 4'hf;
   // region mode per select
   typedef enum logic [1:0] {MODE_STATIC, MODE_FPDRAM, MODE_SDRAM}
      region_mode_t;
endpackage

// ===== core/sel_fifo_reg.sv
`timescale 1ns/1ps
// per-region decode: base/mask compare, window limited to the address width
module sel_fifo_reg #(
   parameter int AW = 28
) (
   input wire logic clk_i, // bus clock
   input wire logic nrst_i, // async reset, low
   input wire logic [AW-1:0] addr_i, // cycle address
   input wire logic [AW-1:0] base_i, // region base
   input wire logic [AW-1:0] mask_i, // region mask, 1 = compared
   input wire logic en_i, // region enabled
   output logic hit_o // registered match
);
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         hit_o <= 1'b0;
      end else begin
         // 28 address bits bound every window to 256 Mbytes
         hit_o <= en_i && (((addr_i ^ base_i) & mask_i) == '0);
      end
   end
endmodule // sel_fifo_reg

// ===== core/ext_bus_pins.sv
`timescale 1ns/1ps
module ext_bus_pins
   import ext_bus_pkg::*;
#(
   parameter int WAIT_MAX = 16
) (
   input wire logic clk_i, // bus clock
   input wire logic nrst_i, // async reset, low
   // memory module side
   input wire logic req_i, // start a cycle, pulse
   input wire logic req_read_i, // 1 read, 0 write
   input wire logic req_burst_i, // burst cycle
   input wire logic [ext_bus_pkg::ADDR_W-1:0] req_addr_i, // address
   input wire logic [ext_bus_pkg::DATA_W-1:0] req_wdata_i, // write data
   input wire logic [ext_bus_pkg::LANES-1:0] req_lanes_i, // lanes, high=on
   input wire logic [1:0] sdram_cmd_i, // unused upper cmd bits folded
   input wire logic [2:0] sdram_op_i, // sdram command, active low bits
   input wire logic sdram_ap_i, // sdram auto-precharge
   input wire logic [ext_bus_pkg::REGIONS*ext_bus_pkg::ADDR_W-1:0] base_i,
   input wire logic [ext_bus_pkg::REGIONS*ext_bus_pkg::ADDR_W-1:0] mask_i,
   input wire logic [ext_bus_pkg::REGIONS-1:0] region_en_i, // enables
   input wire logic [2*ext_bus_pkg::REGIONS-1:0] region_mode_i, // modes
   output logic busy_o, // cycle in progress
   output logic done_o, // cycle ended, pulse
   output logic err_o, // error end, pulse
   output logic burst_end_o, // normal burst end, pulse
   output logic [ext_bus_pkg::DATA_W-1:0] rdata_o, // read data
   // pins
   output logic [ext_bus_pkg::ADDR_W-1:0] addr_o, // address out
   output logic addr_oe_n_o, // address enable, low drives
   input wire logic [ext_bus_pkg::DATA_W-1:0] data_i, // data in
   output logic [ext_bus_pkg::DATA_W-1:0] data_o, // data out
   output logic data_oe_n_o, // data enable, low drives
   output logic [ext_bus_pkg::LANES-1:0] byte_lane_sel_n_o, // lanes
   output logic byte_lane_sel_oe_n_o, // lane enable, low drives
   output logic rw_o, // direction, high read
   output logic rw_oe_n_o, // direction enable, low drives
   input wire logic cycle_ack_n_i, // ack in
   output logic cycle_ack_n_o, // ack out, observation only
   output logic cycle_ack_oe_n_o, // ack enable, low drives
   input wire logic cycle_err_ack_n_i, // error ack in
   output logic cycle_err_ack_n_o, // error ack out
   output logic cycle_err_ack_oe_n_o, // error ack enable, low drives
   output logic region_sel0_boot_n_o, // boot select
   output logic [ext_bus_pkg::REGIONS-2:0] region_sel_n_o, // selects 1..4
   output logic [ext_bus_pkg::LANES-1:0] col_strobe_n_o, // column strobes
   output logic write_strobe_n_o, // write strobe
   output logic read_strobe_n_o // read strobe
);
   import ext_bus_pkg::*;

   typedef enum logic [1:0] {ST_IDLE, ST_DECODE, ST_ACTIVE, ST_RELEASE}
      state_t;
   state_t state_reg;
   logic [REGIONS-1:0] hit;
   logic [ADDR_W-1:0] addr_reg;
   logic read_reg;
   logic burst_reg;
   logic [LANES-1:0] lanes_reg;
   logic [$clog2(WAIT_MAX+1)-1:0] wait_reg;
   logic [$clog2(REGIONS+1)-1:0] region_reg;
   region_mode_t mode_cur;
   logic ack_seen;
   logic err_seen;
   logic end_cycle;

   genvar g;
   generate
      for (g = 0; g < REGIONS; g++) begin : g_dec
         sel_fifo_reg #(.AW(ADDR_W)) u_dec (
            .clk_i(clk_i),
            .nrst_i(nrst_i),
            // decode the request itself so the hit is ready in decode state
            .addr_i(req_addr_i),
            .base_i(base_i[g*ADDR_W +: ADDR_W]),
            .mask_i(mask_i[g*ADDR_W +: ADDR_W]),
            .en_i(region_en_i[g]),
            .hit_o(hit[g])
         );
      end
   endgenerate

   // inputs are taken synchronous to the bus clock
   assign ack_seen = !cycle_ack_n_i;
   assign err_seen = !cycle_err_ack_n_i;
   // internal timeout makes the device end the cycle itself
   assign end_cycle = ack_seen || err_seen || (wait_reg == '0);
   always_comb begin
      mode_cur = MODE_STATIC;
      if (region_reg < REGIONS[$bits(region_reg)-1:0]) begin
         mode_cur = region_mode_t'(region_mode_i[2*region_reg +: 2]);
      end
   end

   // cycle sequencing
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         state_reg <= ST_IDLE;
         addr_reg <= '0;
         read_reg <= 1'b1;
         burst_reg <= 1'b0;
         lanes_reg <= '0;
         wait_reg <= '0;
         region_reg <= '0;
      end else begin
         unique case (state_reg)
            ST_IDLE: begin
               if (req_i) begin
                  addr_reg <= req_addr_i;
                  read_reg <= req_read_i;
                  burst_reg <= req_burst_i;
                  lanes_reg <= req_lanes_i;
                  state_reg <= ST_DECODE;
               end
            end
            ST_DECODE: begin
               // lowest hit wins; boot select has priority
               region_reg <= REGIONS[$bits(region_reg)-1:0];
               for (int i = REGIONS - 1; i >= 0; i--) begin
                  if (hit[i]) begin
                     region_reg <= i[$bits(region_reg)-1:0];
                  end
               end
               wait_reg <= WAIT_MAX[$bits(wait_reg)-1:0];
               state_reg <= ST_ACTIVE;
            end
            ST_ACTIVE: begin
               wait_reg <= wait_reg - 1'b1;
               // error alone ends any burst too
               if (end_cycle) begin
                  state_reg <= ST_RELEASE;
               end
            end
            ST_RELEASE: begin
               state_reg <= ST_IDLE;
            end
         endcase
      end
   end

   // completion reporting toward the memory module
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         busy_o <= 1'b0;
         done_o <= 1'b0;
         err_o <= 1'b0;
         burst_end_o <= 1'b0;
         rdata_o <= '0;
      end else begin
         busy_o <= (state_reg != ST_IDLE) || req_i;
         done_o <= (state_reg == ST_ACTIVE) && end_cycle;
         err_o <= (state_reg == ST_ACTIVE) &&
            ((err_seen && !ack_seen) || (!ack_seen && wait_reg == '0));
         burst_end_o <= (state_reg == ST_ACTIVE) && burst_reg &&
            err_seen && ack_seen;
         if (state_reg == ST_ACTIVE && ack_seen && read_reg) begin
            rdata_o <= data_i;
         end
      end
   end

   // address, data, lanes and direction pins
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         addr_o <= '0;
         addr_oe_n_o <= 1'b1;
         data_o <= '0;
         data_oe_n_o <= 1'b1;
         byte_lane_sel_n_o <= LANES_IDLE;
         byte_lane_sel_oe_n_o <= 1'b1;
         rw_o <= 1'b1;
         rw_oe_n_o <= 1'b1;
      end else if (state_reg == ST_DECODE || state_reg == ST_ACTIVE) begin
         addr_o <= addr_reg;
         addr_oe_n_o <= 1'b0;
         data_o <= req_wdata_i;
         data_oe_n_o <= read_reg;
         byte_lane_sel_n_o <= ~lanes_reg;
         byte_lane_sel_oe_n_o <= 1'b0;
         rw_o <= read_reg;
         rw_oe_n_o <= 1'b0;
      end else begin
         addr_oe_n_o <= 1'b1;
         data_oe_n_o <= 1'b1;
         byte_lane_sel_n_o <= LANES_IDLE;
         byte_lane_sel_oe_n_o <= 1'b1;
         rw_o <= 1'b1;
         rw_oe_n_o <= 1'b1;
      end
   end

   // error ack mirror: low on timeout end, then high one cycle, then release; ack mirror never driven
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         cycle_ack_n_o <= 1'b1;
         cycle_ack_oe_n_o <= 1'b1;
         cycle_err_ack_n_o <= 1'b1;
         cycle_err_ack_oe_n_o <= 1'b1;
      end else if (state_reg == ST_ACTIVE && wait_reg == '0 &&
                   !ack_seen && !err_seen) begin
         // no external answer: device ends the cycle with an error
         cycle_err_ack_n_o <= 1'b0;
         cycle_err_ack_oe_n_o <= 1'b0;
      end else if (state_reg == ST_RELEASE) begin
         cycle_ack_n_o <= 1'b1;
         cycle_err_ack_n_o <= 1'b1;
      end else begin
         cycle_ack_oe_n_o <= 1'b1;
         cycle_err_ack_oe_n_o <= 1'b1;
         cycle_ack_n_o <= 1'b1;
         cycle_err_ack_n_o <= 1'b1;
      end
   end

   // region selects, column strobes and read/write strobes
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         region_sel0_boot_n_o <= 1'b1;
         region_sel_n_o <= '1;
         col_strobe_n_o <= COL_IDLE;
         write_strobe_n_o <= 1'b1;
         read_strobe_n_o <= 1'b1;
      end else if (state_reg == ST_ACTIVE && !end_cycle &&
                   region_reg < REGIONS[$bits(region_reg)-1:0]) begin
         region_sel0_boot_n_o <= (region_reg != '0);
         for (int i = 1; i < REGIONS; i++) begin
            region_sel_n_o[i-1] <= (region_reg != i[$bits(region_reg)-1:0]);
         end
         unique case (mode_cur)
            MODE_FPDRAM: col_strobe_n_o <= ~lanes_reg;
            MODE_SDRAM: col_strobe_n_o <= {sdram_op_i, !sdram_ap_i};
            default: col_strobe_n_o <= COL_IDLE;
         endcase
         write_strobe_n_o <= read_reg;
         read_strobe_n_o <= !read_reg;
      end else begin
         region_sel0_boot_n_o <= 1'b1;
         region_sel_n_o <= '1;
         col_strobe_n_o <= COL_IDLE;
         write_strobe_n_o <= 1'b1;
         read_strobe_n_o <= 1'b1;
      end
   end
endmodule // ext_bus_pins

// ===== sim/ext_bus_pins_monitor.sv
`timescale 1ns/1ps
module ext_bus_pins_monitor
   import ext_bus_pkg::*;
#(
   parameter int WAIT_MAX = 16
) (
   input wire logic clk_i, // clock
   input wire logic nrst_i, // reset
   input wire logic busy_o, // busy
   input wire logic done_o, // done
   input wire logic err_o, // error
   input wire logic rw_o, // direction
   input wire logic rw_oe_n_o, // dir enable
   input wire logic data_oe_n_o, // data enable
   input wire logic [ext_bus_pkg::ADDR_W-1:0] addr_o, // address
   input wire logic cycle_ack_n_i, // ack
   input wire logic cycle_err_ack_n_i, // err ack
   input wire logic cycle_ack_oe_n_o, // ack enable
   input wire logic cycle_err_ack_n_o, // err ack out
   input wire logic cycle_err_ack_oe_n_o, // err ack enable
   input wire logic region_sel0_boot_n_o, // boot select
   input wire logic [ext_bus_pkg::REGIONS-2:0] region_sel_n_o, // selects
   input wire logic [ext_bus_pkg::LANES-1:0] col_strobe_n_o, // columns
   input wire logic write_strobe_n_o, // write strobe
   input wire logic read_strobe_n_o // read strobe
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (!nrst_i);
   wire logic strb = !(read_strobe_n_o && write_strobe_n_o);
   logic [4:0] sel;
   assign sel = ~{region_sel_n_o, region_sel0_boot_n_o};
   property p_ack; strb && !cycle_ack_n_i && cycle_err_ack_n_i |=> done_o;
   endproperty
   a_ack: assert property (p_ack) else $error("ack not ended");
   property p_err; strb && !cycle_err_ack_n_i && cycle_ack_n_i |=> err_o;
   endproperty
   a_err: assert property (p_err) else $error("no error end");
   property p_rd; !read_strobe_n_o |-> rw_o && !rw_oe_n_o && data_oe_n_o;
   endproperty
   a_rd: assert property (p_rd) else $error("read pins");
   property p_wr; !write_strobe_n_o |-> !rw_o && !data_oe_n_o; endproperty
   a_wr: assert property (p_wr) else $error("write pins");
   property p_busy; strb |-> busy_o; endproperty
   a_busy: assert property (p_busy) else $error("idle strobe");
   property p_col; sel == 5'h00 |-> col_strobe_n_o == COL_IDLE; endproperty
   a_col: assert property (p_col) else $error("column active");
   property p_one; $countones(sel) <= 1; endproperty
   a_one: assert property (p_one) else $error("two selects");
   property p_addr; strb ##1 strb |-> $stable(addr_o); endproperty
   a_addr: assert property (p_addr) else $error("address moved");
   property p_rel; $rose(cycle_err_ack_oe_n_o) |-> $past(cycle_err_ack_n_o);
   endproperty
   a_rel: assert property (p_rel) else $error("released low");
   property p_ackoe; cycle_ack_oe_n_o; endproperty
   a_ackoe: assert property (p_ackoe) else $error("ack driven");
   c_read: cover property (!read_strobe_n_o ##2 done_o);
   c_write: cover property (!write_strobe_n_o ##1 done_o);
   c_err: cover property (err_o);
endmodule // ext_bus_pins_monitor
bind ext_bus_pins ext_bus_pins_monitor #(.WAIT_MAX(WAIT_MAX)) u_mon (
   .clk_i(clk_i),
   .nrst_i(nrst_i),
   .busy_o(busy_o),
   .done_o(done_o),
   .err_o(err_o),
   .rw_o(rw_o),
   .rw_oe_n_o(rw_oe_n_o),
   .data_oe_n_o(data_oe_n_o),
   .addr_o(addr_o),
   .cycle_ack_n_i(cycle_ack_n_i),
   .cycle_err_ack_n_i(cycle_err_ack_n_i),
   .cycle_ack_oe_n_o(cycle_ack_oe_n_o),
   .cycle_err_ack_n_o(cycle_err_ack_n_o),
   .cycle_err_ack_oe_n_o(cycle_err_ack_oe_n_o),
   .region_sel0_boot_n_o(region_sel0_boot_n_o),
   .region_sel_n_o(region_sel_n_o),
   .col_strobe_n_o(col_strobe_n_o),
   .write_strobe_n_o(write_strobe_n_o),
   .read_strobe_n_o(read_strobe_n_o)
);

// ===== sim/periph_model.sv
`timescale 1ns/1ps
module periph_model (
   input wire logic clk_i, // bus clock
   input wire logic sel_n_i, // low while a strobe is low
   input wire logic rd_n_i, // read strobe
   input wire logic [1:0] mode_i, // 0 ack, 1 error, 2 both, 3 silent
   input wire logic [3:0] delay_i, // wait states
   input wire logic [31:0] rdata_i, // word returned on reads
   output logic ack_n_o, // reads 1 when released, pull-up
   output logic err_n_o, // reads 1 when released, pull-up
   output logic [31:0] data_o // read data
);
   logic [3:0] cnt_reg;
   logic hit;
   initial begin
      {cnt_reg, ack_n_o, err_n_o} = 6'h03;
   end
   assign hit = !sel_n_i && cnt_reg == delay_i;
   // inverse when released so stale data never passes
   assign data_o = rd_n_i ? ~rdata_i : rdata_i;
   // low one cycle only, then high before release
   always @(posedge clk_i) begin
      cnt_reg <= sel_n_i ? 4'h0 : cnt_reg + 4'h1;
      ack_n_o <= !(hit && !mode_i[0]);
      err_n_o <= !(hit && ^mode_i);
   end
endmodule // periph_model

// ===== sim/tb.sv
`timescale 1ns/1ps
module tb;
   import ext_bus_pkg::*;
   logic clk_i, nrst_i, req_i, req_read_i, req_burst_i, sdram_ap_i;
   logic busy_o, done_o, err_o, burst_end_o, addr_oe_n_o, data_oe_n_o;
   logic byte_lane_sel_oe_n_o, rw_o, rw_oe_n_o, cycle_ack_n_o;
   logic cycle_ack_oe_n_o, cycle_err_ack_n_o, cycle_err_ack_oe_n_o;
   logic region_sel0_boot_n_o, write_strobe_n_o, read_strobe_n_o;
   logic m_ack_n, m_err_n, cycle_ack_n_i, cycle_err_ack_n_i;
   logic [27:0] req_addr_i, addr_o;
   logic [31:0] req_wdata_i, data_i, data_o, rdata_o, m_data, wd;
   logic [3:0] req_lanes_i, byte_lane_sel_n_o, col_strobe_n_o, dly;
   logic [3:0] region_sel_n_o;
   logic [1:0] sdram_cmd_i, mode;
   logic [2:0] sdram_op_i;
   logic [139:0] base_i, mask_i;
   logic [4:0] region_en_i;
   logic [9:0] region_mode_i;
   logic [14:0] rec;
   logic [27:0] wa;
   logic [4:0] ln;
   logic [6:0] idle_pins;
   int n_errors, check_count;
   assign cycle_ack_n_i = m_ack_n & (cycle_ack_oe_n_o | cycle_ack_n_o);
   assign cycle_err_ack_n_i = m_err_n & (cycle_err_ack_oe_n_o |
      cycle_err_ack_n_o);
   assign data_i = data_oe_n_o ? m_data : data_o;
   ext_bus_pins #(.WAIT_MAX(4)) dut (.*);
   periph_model u_periph (.clk_i(clk_i), .sel_n_i(read_strobe_n_o &
      write_strobe_n_o), .rd_n_i(read_strobe_n_o), .mode_i(mode),
      .delay_i(dly), .rdata_i(32'h3c5a96e1), .ack_n_o(m_ack_n),
      .err_n_o(m_err_n), .data_o(m_data));
   initial begin
      clk_i = 1'b0;
      forever #2.5 clk_i = ~clk_i;
   end
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         n_errors++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   // rec: read, write, selects, columns, done, err, burst end, err drive
   task automatic run(input logic [31:0] w, input logic [27:0] a,
         input logic [9:0] c, input logic [14:0] exp);
      int i;
      rec = '0;
      wa = '0;
      ln = '1;
      @(posedge clk_i);
      // c packs read, burst, lanes, model mode and a two-bit wait count
      {req_read_i, req_burst_i, req_lanes_i, mode} <= c[9:2];
      dly <= {2'b00, c[1:0]};
      {req_addr_i, req_wdata_i, req_i} <= {a, w, 1'b1};
      @(posedge clk_i);
      req_i <= 1'b0;
      for (i = 0; i < 40; i++) begin
         @(posedge clk_i);
         #1;
         rec |= {~read_strobe_n_o, ~write_strobe_n_o, ~region_sel_n_o,
            ~region_sel0_boot_n_o, ~col_strobe_n_o, done_o, err_o,
            burst_end_o, ~cycle_err_ack_oe_n_o};
         if (!write_strobe_n_o) wd = data_o;
         if (!addr_oe_n_o) begin
            {wa, ln} = {addr_o, byte_lane_sel_oe_n_o, byte_lane_sel_n_o};
         end
         if (rec[3:2] != 2'b00 && !busy_o) break;
      end
      if (i == 40) begin
         n_errors++;
         tally_and_finish();
      end
      check(32'(rec), 32'(exp));
      check(32'(wa), 32'(a));
      check(32'(ln), 32'({1'b0, ~c[7:4]}));
      idle_pins = {addr_oe_n_o, data_oe_n_o, byte_lane_sel_oe_n_o, rw_oe_n_o,
         rw_o, cycle_ack_n_o, cycle_ack_oe_n_o};
      check(32'(idle_pins), 32'h7f);
      $display("cycle to %h ended", a);
   endtask
   task automatic t_boot_read;
      run('0, 28'h0000010, 10'h2f1, 15'h4108);
      check(rdata_o, 32'h3c5a96e1);
   endtask
   task automatic t_static_write;
      run(32'ha5a55a5a, 28'h3000004, 10'h0f0, 15'h2808);
      check(wd, 32'ha5a55a5a);
   endtask
   task automatic t_dram_lanes;
      run('0, 28'h1000020, 10'h261, 15'h4268);
   endtask
   task automatic t_sdram_cmd;
      run(32'h0f0f1234, 28'h2000000, 10'h0f0, 15'h24b8);
   endtask
   task automatic t_error_end;
      run('0, 28'h0000100, 10'h2f4, 15'h410c);
   endtask
   task automatic t_burst_end;
      run('0, 28'h0000200, 10'h3f8, 15'h410a);
   endtask
   task automatic t_no_region;
      run('0, 28'h4000000, 10'h2fc, 15'h000d);
   endtask
   initial begin
      {nrst_i, req_i, req_read_i, req_burst_i, req_addr_i} = '0;
      {req_wdata_i, req_lanes_i, mode, dly, sdram_cmd_i} = '0;
      {n_errors, check_count, sdram_op_i, sdram_ap_i} = {32'd0, 32'd0, 4'h5};
      base_i = {28'h4000000, 28'h3000000, 28'h2000000, 28'h1000000, 28'h0};
      mask_i = {5{28'hf000000}};
      region_en_i = 5'h0f;
      region_mode_i = {MODE_STATIC, MODE_STATIC, MODE_SDRAM, MODE_FPDRAM,
         MODE_STATIC};
      repeat (20) @(posedge clk_i);
      nrst_i <= 1'b1;
      t_boot_read();
      t_static_write();
      t_dram_lanes();
      t_sdram_cmd();
      t_error_end();
      t_burst_end();
      t_no_region();
      tally_and_finish();
   end
endmodule // tb
